// ===== bbp_port.sv
// One channel of the bit-bang parallel port: mode control, pin sequencer, flush/wake.
`timescale 1ns/10ps
module bbp_port (
    input  wire logic              I_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_CE,
    input  wire logic              I_ENUMERATED,
    input  wire logic              I_CMD_VALID,
    input  wire bbp_pkg::bbp_cmd_t I_CMD,
    input  wire logic              I_RX_VALID,
    input  wire logic [7:0]        I_RX_DATA,
    output logic                   O_RX_READY,
    output logic                   O_TX_VALID,
    output logic [7:0]             O_TX_DATA,
    input  wire logic              I_TX_READY,
    input  wire logic              I_BAUD_TICK,
    input  wire logic [7:0]        I_PIN_IN,
    output bbp_pkg::bbp_pins_t     O_PINS,
    output logic                   O_PIN_SAMPLE_STROBE_N,
    output logic                   O_PIN_UPDATE_STROBE_N,
    input  wire logic              I_FLUSH_OR_WAKE_N,
    input  wire logic              I_SUSPENDED,
    input  wire logic              I_WAKE_PULLDOWN_EN,
    output logic                   O_SEND_IMMEDIATE,
    output logic                   O_WAKE_REQ
);
    import bbp_pkg::*;

    // ==========================================================================
    // Declarations
    // ==========================================================================
    bbp_mode_t  mode_r, mode_nxt;
    logic [7:0] dir_r, dir_nxt;
    bbp_state_t state_r, state_nxt;
    logic [7:0] out_r, out_nxt;
    logic [7:0] oe_r, oe_nxt;
    logic [7:0] sample_r, sample_nxt;
    logic       rd_n_r, rd_n_nxt;
    logic       wr_n_r, wr_n_nxt;
    logic       push_r, push_nxt;
    logic       rx_ready_r, rx_ready_nxt;
    logic       flush_prev_r, flush_prev_nxt;
    logic       send_r, send_nxt;
    logic       wake_r, wake_nxt;
    logic [8:0] syn;
    logic [7:0] pin_sync;
    logic       flush_sync;
    logic       flush_fall;
    logic       rx_take;
    logic       buf_in_ready;
    logic       cmd_take;

    // ==========================================================================
    // Input synchronisers and sample buffer
    // ==========================================================================
    bbp_sync #(
        .W         (SYN_W),
        .RESET_VAL (RESET_PIN_SYN)
    ) u_sync (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_ce      (I_CE),
        .i_async   ({I_FLUSH_OR_WAKE_N, I_PIN_IN}),
        .o_sync    (syn)
    );

    assign pin_sync   = syn[7:0];
    assign flush_sync = syn[8];

    // A stalled transmit side fills this buffer and then holds the sequencer in sync mode; async mode still takes bytes and drops samples.
    bbp_buf2 #(
        .W (PORT_W)
    ) u_buf (
        .i_clk       (I_CLK),
        .i_reset_n   (I_RESET_N),
        .i_ce        (I_CE),
        .i_in_valid  (push_r),
        .i_in_data   (sample_r),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (O_TX_VALID),
        .o_out_data  (O_TX_DATA),
        .i_out_ready (I_TX_READY)
    );

    // ==========================================================================
    // Mode and direction
    // ==========================================================================
    assign cmd_take = I_CMD_VALID && I_ENUMERATED;

    always_comb begin
        mode_nxt = mode_r;
        dir_nxt  = dir_r;
        if (cmd_take) begin
            case (I_CMD.mode)
                CMD_ASYNC_BB: mode_nxt = MODE_ASYNC;
                CMD_SYNC_BB:  mode_nxt = MODE_SYNC;
                default:      mode_nxt = MODE_SERIAL;
            endcase
            dir_nxt = I_CMD.dir_mask;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mode_r <= MODE_SERIAL;
            dir_r  <= RESET_DIR;
        end else if (I_CE) begin
            mode_r <= mode_nxt;
            dir_r  <= dir_nxt;
        end
    end

    // ==========================================================================
    // Pin sequencer
    // ==========================================================================
    // Each channel of the device is one instance of this module.
    assign rx_take = rx_ready_r && I_RX_VALID;

    always_comb begin
        state_nxt    = state_r;
        out_nxt      = out_r;
        sample_nxt   = sample_r;
        rd_n_nxt     = 1'b1;
        wr_n_nxt     = 1'b1;
        push_nxt     = 1'b0;
        rx_ready_nxt = 1'b0;
        // Pins move only when a byte is actually taken.
        if (rx_take) begin
            out_nxt = I_RX_DATA;
        end
        // Serial mode hands the pins back to the serial engine.
        oe_nxt = (mode_r == MODE_SERIAL) ? 8'h00 : dir_r;
        case (state_r)
            S_IDLE: begin
                // A byte starts a full cycle even with every pin an input.
                if (mode_r == MODE_SYNC && I_RX_VALID && buf_in_ready) begin
                    state_nxt  = S_READ;
                    rd_n_nxt   = 1'b0;
                    sample_nxt = pin_sync;
                end else if (mode_r == MODE_ASYNC && I_BAUD_TICK) begin
                    if (I_RX_VALID) begin
                        state_nxt    = S_ATAKE;
                        rx_ready_nxt = 1'b1;
                    end
                    if (buf_in_ready && !push_r) begin
                        rd_n_nxt   = 1'b0;
                        sample_nxt = pin_sync;
                        push_nxt   = 1'b1;
                    end
                end
            end
            S_READ: begin
                // Strobe rises as the captured sample heads for the host.
                state_nxt    = S_SEND;
                push_nxt     = 1'b1;
                rx_ready_nxt = 1'b1;
            end
            S_SEND: begin
                state_nxt = S_SETUP;
            end
            S_SETUP: begin
                state_nxt = S_WRITE;
                wr_n_nxt  = 1'b0;
            end
            S_WRITE: begin
                state_nxt = S_IDLE;
            end
            S_ATAKE: begin
                state_nxt = S_AWRITE;
                wr_n_nxt  = 1'b0;
            end
            S_AWRITE: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r    <= S_IDLE;
            out_r      <= RESET_OUT;
            oe_r       <= RESET_DIR;
            sample_r   <= RESET_SAMPLE;
            rd_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            push_r     <= 1'b0;
            rx_ready_r <= 1'b0;
        end else if (I_CE) begin
            state_r    <= state_nxt;
            out_r      <= out_nxt;
            oe_r       <= oe_nxt;
            sample_r   <= sample_nxt;
            rd_n_r     <= rd_n_nxt;
            wr_n_r     <= wr_n_nxt;
            push_r     <= push_nxt;
            rx_ready_r <= rx_ready_nxt;
        end
    end

    assign O_PINS.out            = out_r;
    assign O_PINS.oe             = oe_r;
    assign O_PIN_SAMPLE_STROBE_N = rd_n_r;
    assign O_PIN_UPDATE_STROBE_N = wr_n_r;
    assign O_RX_READY            = rx_ready_r;

    // ==========================================================================
    // Flush and wake-up
    // ==========================================================================
    // Pulse width is the far side's business; any clean falling edge counts.
    assign flush_fall = flush_prev_r && !flush_sync;

    always_comb begin
        flush_prev_nxt = flush_sync;
        send_nxt       = flush_fall && (mode_r != MODE_SERIAL);
        wake_nxt       = flush_fall && I_SUSPENDED && !I_WAKE_PULLDOWN_EN;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            flush_prev_r <= 1'b1;
            send_r       <= 1'b0;
            wake_r       <= 1'b0;
        end else if (I_CE) begin
            flush_prev_r <= flush_prev_nxt;
            send_r       <= send_nxt;
            wake_r       <= wake_nxt;
        end
    end

    assign O_SEND_IMMEDIATE = send_r;
    assign O_WAKE_REQ       = wake_r;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    property p_mode_sync;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_CE && cmd_take && I_CMD.mode == CMD_SYNC_BB) |=> (mode_r == MODE_SYNC);
    endproperty
    a_mode_sync: assert property (p_mode_sync) else $error("sync mode not entered");

    property p_no_mode_before_enum;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !I_ENUMERATED |=> $stable(mode_r);
    endproperty
    a_no_mode_before_enum: assert property (p_no_mode_before_enum)
        else $error("mode changed before enumeration");

    property p_dir_hold;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !cmd_take |=> $stable(dir_r);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed without command");

    property p_dir_to_oe;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_CE && cmd_take && I_CMD.mode == CMD_ASYNC_BB) ##1 I_CE
            |=> (O_PINS.oe == $past(I_CMD.dir_mask, 2));
    endproperty
    a_dir_to_oe: assert property (p_dir_to_oe) else $error("output enables differ from mask");

    property p_out_only_on_take;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !(I_CE && rx_take) |=> $stable(O_PINS.out);
    endproperty
    a_out_only_on_take: assert property (p_out_only_on_take)
        else $error("pins changed without a byte");

    property p_async_needs_tick;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_r == S_IDLE && mode_r == MODE_ASYNC && !I_BAUD_TICK) |=> !O_RX_READY;
    endproperty
    a_async_needs_tick: assert property (p_async_needs_tick)
        else $error("byte taken without baud tick");

    property p_sync_room;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_r == S_IDLE && mode_r == MODE_SYNC && !buf_in_ready) |=> (state_r == S_IDLE);
    endproperty
    a_sync_room: assert property (p_sync_room) else $error("byte handled without room");

    property p_sample_then_push;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_r == S_READ && I_CE) |=> (push_r && $rose(O_PIN_SAMPLE_STROBE_N) && O_RX_READY);
    endproperty
    a_sample_then_push: assert property (p_sample_then_push)
        else $error("sample not pushed at strobe rise");

    property p_sample_before_drive;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_r == S_READ && I_CE) |-> $stable(O_PINS.out) && !O_PIN_SAMPLE_STROBE_N;
    endproperty
    a_sample_before_drive: assert property (p_sample_before_drive)
        else $error("pins driven before sampling");

    property p_setup_then_write;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_r == S_SEND && I_CE) ##1 I_CE |=> !O_PIN_UPDATE_STROBE_N;
    endproperty
    a_setup_then_write: assert property (p_setup_then_write)
        else $error("write strobe not after setup clock");

    property p_strobe_short;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (!O_PIN_UPDATE_STROBE_N && I_CE) |=> O_PIN_UPDATE_STROBE_N;
    endproperty
    a_strobe_short: assert property (p_strobe_short) else $error("write strobe stuck low");

    property p_wake_blocked;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WAKE_PULLDOWN_EN && I_CE) |=> !O_WAKE_REQ;
    endproperty
    a_wake_blocked: assert property (p_wake_blocked) else $error("wake with pull-down on");

    property p_flush;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (I_CE && flush_fall && mode_r != MODE_SERIAL) |=> O_SEND_IMMEDIATE;
    endproperty
    a_flush: assert property (p_flush) else $error("flush edge not flagged");

    c_sync_cycle: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
        state_r == S_SETUP ##1 state_r == S_WRITE);
    c_async_take: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
        state_r == S_ATAKE && rx_take);
    c_buf_full: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
        mode_r == MODE_SYNC && !buf_in_ready);
    c_wake: cover property (@(posedge I_CLK) disable iff (!I_RESET_N) O_WAKE_REQ);
endmodule

// ===== bbp_pkg.sv
// Shared types and constants for the bit-bang parallel port channel.
package bbp_pkg;

    // ==========================================================================
    // Mode-setting command values
    // ==========================================================================
    localparam logic [7:0] CMD_ASYNC_BB  = 8'h01;
    localparam logic [7:0] CMD_SYNC_BB   = 8'h04;

    // ==========================================================================
    // Values after reset
    // ==========================================================================
    localparam logic [7:0] RESET_DIR     = 8'h00;
    localparam logic [7:0] RESET_OUT     = 8'h00;
    localparam logic [7:0] RESET_SAMPLE  = 8'h00;
    // The flush/wake input idles high, so its synchroniser starts high.
    localparam logic [8:0] RESET_PIN_SYN = 9'h1FF;
    localparam int         PORT_W        = 8;
    localparam int         SYN_W         = 9;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        MODE_SERIAL = 2'b00,
        MODE_ASYNC  = 2'b01,
        MODE_SYNC   = 2'b10
    } bbp_mode_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_READ   = 3'b001,
        S_SEND   = 3'b010,
        S_SETUP  = 3'b011,
        S_WRITE  = 3'b100,
        S_ATAKE  = 3'b101,
        S_AWRITE = 3'b110
    } bbp_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] dir_mask;
    } bbp_cmd_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } bbp_pins_t;

endpackage

// ===== bbp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/10ps
module bbp_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else if (i_ce) begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// ===== bbp_buf2.sv
// Two-entry valid/ready buffer with registered outputs.
`timescale 1ns/10ps
module bbp_buf2 #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_ce,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic      [W-1:0] o_out_data,
    input  wire logic         i_out_ready
);
    logic [W-1:0] d0_r, d1_r, d0_nxt, d1_nxt;
    logic         v0_r, v1_r, v0_nxt, v1_nxt;

    always_comb begin
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        v0_nxt = v0_r;
        v1_nxt = v1_r;
        if (v0_r && i_out_ready) begin
            d0_nxt = d1_r;
            v0_nxt = v1_r;
            v1_nxt = 1'b0;
        end
        // Ready is a registered "second slot free", so a push never overruns.
        if (i_in_valid && !v1_r) begin
            if (!v0_nxt) begin
                d0_nxt = i_in_data;
                v0_nxt = 1'b1;
            end else begin
                d1_nxt = i_in_data;
                v1_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            d0_r <= '0;
            d1_r <= '0;
            v0_r <= 1'b0;
            v1_r <= 1'b0;
        end else if (i_ce) begin
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
            v0_r <= v0_nxt;
            v1_r <= v1_nxt;
        end
    end

    assign o_in_ready  = !v1_r;
    assign o_out_valid = v0_r;
    assign o_out_data  = d0_r;
endmodule

// ===== bbp_ext_logic.sv
// Behavioural model of the external parallel logic clocked by the port strobes.
`timescale 1ns/10ps
module bbp_ext_logic (
    input  wire logic               i_reset_n,
    input  wire bbp_pkg::bbp_pins_t i_pins,
    input  wire logic [7:0]         i_ext_drive,
    input  wire logic               i_sample_strobe_n,
    input  wire logic               i_update_strobe_n,
    output logic      [7:0]         o_pin_level,
    output logic      [15:0]        o_sample_cnt,
    output logic      [15:0]        o_update_cnt
);
    import bbp_pkg::*;

    // ==========================================================================
    // Pin resolution
    // ==========================================================================
    // The far side drives only the pins that the port leaves undriven.
    always_comb begin
        o_pin_level = (i_pins.out & i_pins.oe) | (i_ext_drive & ~i_pins.oe);
    end

    // ==========================================================================
    // Strobe-clocked counters
    // ==========================================================================
    always @(posedge i_sample_strobe_n or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sample_cnt <= 16'h0000;
        end else begin
            o_sample_cnt <= o_sample_cnt + 16'h0001;
        end
    end

    always @(posedge i_update_strobe_n or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_update_cnt <= 16'h0000;
        end else begin
            o_update_cnt <= o_update_cnt + 16'h0001;
        end
    end
endmodule

// ===== bbp_port_tb_top.sv
// Self-checking testbench for one bit-bang parallel port channel.
`timescale 1ns/10ps
module bbp_port_tb_top;
    import bbp_pkg::*;

    logic clk = 0, rst_n = 0, ce = 1, enum_ok = 0, cmd_v = 0, rx_v = 0, tx_rdy = 1, tick = 0;
    logic fw_n = 1, susp = 0, pd = 0, rx_rdy, tx_v, rs_n, us_n, si, wk;
    logic [7:0] rx_d = 8'h00, ext = 8'h00, tx_d, pin_lvl, cur_out = 8'h00, cur_dir = 8'h00;
    logic [15:0] smp_cnt, upd_cnt;
    bbp_cmd_t   cmd = '0;
    bbp_pins_t  pins;
    logic [7:0] exp_q[$];
    int miscompares = 0, cmp_count = 0, cyc = 0, si_n = 0, wk_n = 0;

    bbp_port bbp_port_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_ENUMERATED(enum_ok),
        .I_CMD_VALID(cmd_v), .I_CMD(cmd), .I_RX_VALID(rx_v), .I_RX_DATA(rx_d),
        .O_RX_READY(rx_rdy), .O_TX_VALID(tx_v), .O_TX_DATA(tx_d), .I_TX_READY(tx_rdy),
        .I_BAUD_TICK(tick), .I_PIN_IN(pin_lvl), .O_PINS(pins), .O_PIN_SAMPLE_STROBE_N(rs_n),
        .O_PIN_UPDATE_STROBE_N(us_n), .I_FLUSH_OR_WAKE_N(fw_n), .I_SUSPENDED(susp),
        .I_WAKE_PULLDOWN_EN(pd), .O_SEND_IMMEDIATE(si), .O_WAKE_REQ(wk));

    bbp_ext_logic bbp_ext_logic_i (.i_reset_n(rst_n), .i_pins(pins), .i_ext_drive(ext),
        .i_sample_strobe_n(rs_n), .i_update_strobe_n(us_n), .o_pin_level(pin_lvl),
        .o_sample_cnt(smp_cnt), .o_update_cnt(upd_cnt));

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================================
    // Monitor: samples leaving the buffer and flush/wake pulse cycles
    // ==========================================================================
    always @(posedge clk) begin
        cyc++;
        si_n += int'(si === 1'b1);
        wk_n += int'(wk === 1'b1);
        if (tx_v === 1'b1 && tx_rdy) begin
            if (exp_q.size() == 0) check("tx_unexpected", 16'h0001, 16'h0000);
            else check("tx_sample", {8'h00, tx_d}, {8'h00, exp_q.pop_front()});
        end
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic set_mode(input logic [7:0] m, input logic [7:0] d);
        cmd = '{mode: m, dir_mask: d};
        cmd_v = 1'b1;
        @(posedge clk); #1 cmd_v = 1'b0;
        if (enum_ok) cur_dir = (m == CMD_ASYNC_BB || m == CMD_SYNC_BB) ? d : 8'h00;
        repeat (4) @(posedge clk);
        #1 check("oe", {8'h00, pins.oe}, {8'h00, cur_dir});
        $display("test mode %h done", m);
    endtask

    // One synchronous transfer: sample of the old pins, then new outputs and write strobe.
    task automatic send_sync(input logic [7:0] b);
        int n;
        n = 0;
        exp_q.push_back((cur_out & cur_dir) | (ext & ~cur_dir));
        rx_d = b;
        rx_v = 1'b1;
        while (rx_rdy !== 1'b1 && n < 100) begin
            @(posedge clk); #1 n++;
        end
        check("rx_taken", {15'h0000, rx_rdy}, 16'h0001);
        @(posedge clk); #1 rx_v = 1'b0;
        cur_out = b;
        check("out", {8'h00, pins.out}, {8'h00, b});
        check("setup", {15'h0000, us_n}, 16'h0001);
        @(posedge clk); #1 check("wr_strobe", {15'h0000, us_n}, 16'h0000);
        @(posedge clk); #1 check("wr_release", {15'h0000, us_n}, 16'h0001);
    endtask

    task automatic async_step(input bit byte_on, input bit tick_on, input logic [7:0] b);
        rx_d = b;
        rx_v = byte_on;
        repeat (3) @(posedge clk);
        if (tick_on) exp_q.push_back((cur_out & cur_dir) | (ext & ~cur_dir));
        #1 tick = tick_on;
        @(posedge clk); #1 tick = 1'b0;
        check("async_take", {15'h0000, rx_rdy}, {15'h0000, byte_on & tick_on});
        check("async_rd", {15'h0000, rs_n}, {15'h0000, ~tick_on});
        @(posedge clk); #1;
        if (byte_on && tick_on) begin
            rx_v = 1'b0;
            cur_out = b;
        end
        check("async_out", {8'h00, pins.out}, {8'h00, cur_out});
        check("async_wr", {15'h0000, us_n}, {15'h0000, ~(byte_on & tick_on)});
        repeat (6) @(posedge clk);
        // An untaken byte stays offered; the next step keeps the same data.
        #1 check("async_hold", {8'h00, pins.out}, {8'h00, cur_out});
    endtask

    // The 25-cycle low pulse is the 250 ns flush request of the far side.
    task automatic flush(input int exp_si, input int exp_wk);
        int s0, w0;
        s0 = si_n;
        w0 = wk_n;
        fw_n = 1'b0;
        repeat (25) @(posedge clk);
        #1 fw_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 check("send_now", 16'(si_n - s0), 16'(exp_si));
        check("wake", 16'(wk_n - w0), 16'(exp_wk));
        $display("test flush done");
    endtask

    initial begin
        logic [15:0] s0, u0;
        void'($urandom(32'hB35D0DC3));
        ext = 8'($urandom);
        repeat (8) @(posedge clk);
        #1 check("pins_reset", pins, 16'h0000);
        check("strobes_idle", {14'h0000, rs_n, us_n}, 16'h0003);
        rst_n = 1'b1;
        set_mode(CMD_SYNC_BB, 8'hFF);
        flush(0, 0);
        enum_ok = 1'b1;
        set_mode(CMD_SYNC_BB, 8'hFF);
        s0 = smp_cnt;
        u0 = upd_cnt;
        send_sync(8'h55);
        send_sync(8'hAA);
        send_sync(8'hAA);
        repeat (4) send_sync(8'($urandom));
        check("rd_strobes", smp_cnt - s0, 16'h0007);
        check("wr_strobes", upd_cnt - u0, 16'h0007);
        $display("test sync done");
        set_mode(CMD_SYNC_BB, 8'h0F);
        repeat (3) send_sync(8'($urandom));
        check("dir_kept", {8'h00, pins.oe}, 16'h000F);
        set_mode(CMD_SYNC_BB, 8'h00);
        repeat (2) send_sync(8'($urandom));
        tx_rdy = 1'b0;
        send_sync(8'h3C);
        send_sync(8'hC3);
        fork
            send_sync(8'h5A);
            begin
                repeat (30) begin
                    @(posedge clk); #1 check("full_wait", {15'h0000, rx_rdy}, 16'h0000);
                end
                tx_rdy = 1'b1;
            end
        join
        $display("test stall done");
        susp = 1'b1;
        flush(1, 1);
        pd = 1'b1;
        flush(1, 0);
        susp = 1'b0;
        pd = 1'b0;
        flush(1, 0);
        set_mode(CMD_ASYNC_BB, 8'hF0);
        async_step(1, 1, 8'($urandom));
        async_step(0, 1, 8'h00);
        async_step(1, 0, 8'h99);
        async_step(1, 1, 8'h99);
        $display("test async done");
        set_mode(8'h02, 8'hFF);
        flush(0, 0);
        // With the clock enable low a standing command must not be taken.
        ce = 1'b0;
        cmd = '{mode: CMD_SYNC_BB, dir_mask: 8'hFF};
        cmd_v = 1'b1;
        repeat (4) @(posedge clk);
        #1 check("ce_freeze", {8'h00, pins.oe}, 16'h0000);
        cmd_v = 1'b0;
        ce = 1'b1;
        $display("test clock enable done");
        repeat (20) @(posedge clk);
        check("queue_empty", 16'(exp_q.size()), 16'h0000);
        conclude();
    end
endmodule
